// ---- rtl/rprst_regs.vh ----
/*
 * Register map, field positions, codes and timing constants of the
 * port reset and link-state control block.
 * Assumes: included by the design files by bare name; no other definitions.
 */
`ifndef RPRST_REGS_VH
`define RPRST_REGS_VH

// apb byte addresses
`define RPRST_ADDR_PORT_STATUS_CONTROL    12'h000
`define RPRST_ADDR_CTRL      12'h004
`define RPRST_ADDR_STATUS    12'h008

// port_status_control fields
`define RPRST_BIT_PED        1
`define RPRST_BIT_RSVD       2
`define RPRST_BIT_OCA        3
`define RPRST_BIT_PR         4
`define RPRST_PLS_LO         5
`define RPRST_PLS_HI         8
`define RPRST_BIT_PP         9
`define RPRST_BIT_LWS        16

// ctrl register fields
`define RPRST_CTRL_USB3      0
`define RPRST_CTRL_PP        1

// status register fields
`define RPRST_STAT_BUSY      0
`define RPRST_STAT_USB2      1
`define RPRST_STAT_USB3      2

// link state codes
`define RPRST_LS_U0          4'h0
`define RPRST_LS_U1          4'h1
`define RPRST_LS_U2          4'h2
`define RPRST_LS_U3          4'h3
`define RPRST_LS_DISABLED    4'h4
`define RPRST_LS_RECEIVER_DETECT_STATE    4'h5
`define RPRST_LS_POLLING     4'h7

// timing: bus reset signalling length in microseconds, at 50 MHz
`define RPRST_CLK_MHZ        50
`define RPRST_RESET_US       10

`endif

// ---- rtl/rprst_sync2.v ----
/*
 * Two flip-flop synchroniser for one asynchronous level.
 * Assumes: input comes from a pin outside the clk domain.
 */
`timescale 1ns/1ns
module rprst_sync2 (
    // clock and reset
    input  wire clk,
    input  wire nrst,
    // level
    input  wire din,
    output reg  dout
);
    reg stage1;

    // stage1 feeds dout only
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage1 <= 1'b0;
            dout   <= 1'b0;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule // rprst_sync2

// ---- rtl/rprst_timer.v ----
/*
 * Down counter that times the bus reset signalling.
 * Assumes: start is a one-cycle pulse on the clk domain.
 */
`timescale 1ns/1ns
module rprst_timer #(
    parameter WIDTH = 16
) (
    // clock and reset
    input  wire             clk,
    input  wire             nrst,
    // control
    input  wire             start,
    input  wire             abort,
    input  wire [WIDTH-1:0] load,
    output wire             busy,
    output reg              done
);
    reg [WIDTH-1:0] count;

    assign busy = (count != {WIDTH{1'b0}});

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count <= {WIDTH{1'b0}};
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                count <= {WIDTH{1'b0}};
            end else if (start) begin
                count <= load;
            end else if (busy) begin
                count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
                if (count == {{(WIDTH-1){1'b0}}, 1'b1}) begin
                    done <= 1'b1;
                end
            end
        end
    end
endmodule // rprst_timer

// ---- rtl/rprst_port.v ----
/*
 * Port reset request, over-current indicator and link-state write control
 * of one root-hub port, with an apb slave for its registers.
 * Assumes: one 50 MHz clock; overcurrent, link status and reset fail pins come
 * from outside and are synchronised here; the attached link phy obeys
 * link_target and the reset strobes.
 */
`timescale 1ns/1ns
`include "rprst_regs.vh"

module rprst_port #(
    parameter        RESET_US = `RPRST_RESET_US,
    parameter        TWIDTH   = 16
) (
    // clock and reset
    input  wire        clk,
    input  wire        nrst,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    // port pins
    input  wire        overcurrent_pin,
    input  wire [3:0]  link_state_pin,
    input  wire        reset_fail_pin,
    // to link phy
    output reg         usb2_bus_reset,
    output reg         usb3_hot_reset,
    output reg  [3:0]  link_target,
    output reg         link_target_valid,
    output wire        downstream_forward_enable,
    // neighbouring port logic
    input  wire        port_enabled_in,
    output reg         port_enabled_flag
);
    // the product is 32 bits wide; the timer keeps only its low TWIDTH bits,
    // so RESET_US must stay small enough for the count to fit TWIDTH
    localparam integer RESET_CYCLES = RESET_US * `RPRST_CLK_MHZ;

    // fsm states
    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_RESET = 3'b010;
    localparam [2:0] ST_DONE  = 3'b100;

    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg         usb3_mode;
    reg         port_power_flag;
    reg         port_reset_request;
    reg  [3:0]  link_state_field;
    reg  [3:0]  ls_sync1;
    reg  [3:0]  ls_sync2;
    reg         ena_q;
    wire        overcurrent_active;
    wire        reset_fail;
    wire        timer_busy;
    wire        timer_done;
    wire        wr_en;
    wire        rd_en;
    wire        addr_ok;
    wire        pr_start;
    wire        lws_write;
    wire [3:0]  wr_pls;
    reg  [31:0] read_mux;
    wire [31:0] reset_cycles_word;

    assign reset_cycles_word = RESET_CYCLES;

    assign pready  = 1'b1;
    assign addr_ok = (paddr == `RPRST_ADDR_PORT_STATUS_CONTROL) || (paddr == `RPRST_ADDR_CTRL)
                     || (paddr == `RPRST_ADDR_STATUS);
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !penable && !pwrite;

    rprst_sync2 u_oc_sync (
        .clk  (clk),
        .nrst (nrst),
        .din  (overcurrent_pin),
        .dout (overcurrent_active)
    );

    rprst_sync2 u_fail_sync (
        .clk  (clk),
        .nrst (nrst),
        .din  (reset_fail_pin),
        .dout (reset_fail)
    );

    // vector synchroniser; the phy holds the code stable for many cycles
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ls_sync1 <= `RPRST_LS_RECEIVER_DETECT_STATE;
            ls_sync2 <= `RPRST_LS_RECEIVER_DETECT_STATE;
        end else begin
            ls_sync1 <= link_state_pin;
            ls_sync2 <= ls_sync1;
        end
    end

    assign wr_pls    = pwdata[`RPRST_PLS_HI:`RPRST_PLS_LO];
    assign lws_write = wr_en && (paddr == `RPRST_ADDR_PORT_STATUS_CONTROL)
                       && pwdata[`RPRST_BIT_LWS];
    // only a 0->1 change starts; a set while already set is dropped
    assign pr_start  = wr_en && (paddr == `RPRST_ADDR_PORT_STATUS_CONTROL) && port_power_flag
                       && pwdata[`RPRST_BIT_PR] && !port_reset_request;

    rprst_timer #(
        .WIDTH (TWIDTH)
    ) u_timer (
        .clk   (clk),
        .nrst  (nrst),
        .start (pr_start),
        .abort (!port_power_flag),
        .load  (reset_cycles_word[TWIDTH-1:0]),
        .busy  (timer_busy),
        .done  (timer_done)
    );

    // reset sequencing
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE:  if (pr_start) next_state = ST_RESET;
            ST_RESET: begin
                if (!port_power_flag) begin
                    next_state = ST_IDLE;
                end else if (timer_done) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE:  next_state = ST_IDLE;
            default:  next_state = ST_IDLE;
        endcase
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state              <= ST_IDLE;
            port_reset_request <= 1'b0;
            usb2_bus_reset     <= 1'b0;
            usb3_hot_reset     <= 1'b0;
            port_enabled_flag  <= 1'b0;
            ena_q              <= 1'b0;
        end else begin
            state <= next_state;
            ena_q <= port_enabled_in;
            if (!port_power_flag) begin
                port_reset_request <= 1'b0;
                usb2_bus_reset     <= 1'b0;
                usb3_hot_reset     <= 1'b0;
                port_enabled_flag  <= 1'b0;
            end else if (pr_start) begin
                port_reset_request <= 1'b1;
                usb2_bus_reset     <= !usb3_mode;
                usb3_hot_reset     <= usb3_mode;
                port_enabled_flag  <= 1'b0;
            end else if (state == ST_DONE) begin
                port_reset_request <= 1'b0;
                usb2_bus_reset     <= 1'b0;
                usb3_hot_reset     <= 1'b0;
                port_enabled_flag  <= !reset_fail;
            end else if (!port_reset_request) begin
                // follows the neighbour's enable/disable decisions
                port_enabled_flag  <= port_enabled_in && ena_q;
            end
        end
    end

    // configuration and link state write handling
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            usb3_mode         <= 1'b0;
            port_power_flag   <= 1'b0;
            link_state_field  <= `RPRST_LS_RECEIVER_DETECT_STATE;
            link_target       <= `RPRST_LS_RECEIVER_DETECT_STATE;
            link_target_valid <= 1'b0;
        end else begin
            link_target_valid <= 1'b0;
            link_state_field  <= ls_sync2;
            if (wr_en && (paddr == `RPRST_ADDR_CTRL)) begin
                usb3_mode       <= pwdata[`RPRST_CTRL_USB3];
                port_power_flag <= pwdata[`RPRST_CTRL_PP];
            end
            if (lws_write && port_power_flag && !port_reset_request) begin
                case (wr_pls)
                    `RPRST_LS_U0: begin
                        if (link_state_field <= `RPRST_LS_U3) begin
                            link_target       <= `RPRST_LS_U0;
                            link_target_valid <= 1'b1;
                        end
                    end
                    `RPRST_LS_U2: begin
                        if (!usb3_mode && port_enabled_flag) begin
                            link_target       <= `RPRST_LS_U2;
                            link_target_valid <= 1'b1;
                        end
                    end
                    `RPRST_LS_U3: begin
                        if (link_state_field == `RPRST_LS_U0 && port_enabled_flag) begin
                            link_target       <= `RPRST_LS_U3;
                            link_target_valid <= 1'b1;
                        end
                    end
                    `RPRST_LS_RECEIVER_DETECT_STATE: begin
                        if (usb3_mode && link_state_field == `RPRST_LS_DISABLED) begin
                            link_target       <= `RPRST_LS_RECEIVER_DETECT_STATE;
                            link_target_valid <= 1'b1;
                        end
                    end
                    default: begin
                        link_target_valid <= 1'b0;
                    end
                endcase
            end
        end
    end

    // suspended or disabled ports carry no downstream traffic
    assign downstream_forward_enable = port_enabled_flag
                                       && (link_state_field != `RPRST_LS_U3);

    always @* begin
        read_mux = 32'h00000000;
        case (paddr)
            `RPRST_ADDR_PORT_STATUS_CONTROL: begin
                read_mux[`RPRST_BIT_PED]                = port_enabled_flag;
                read_mux[`RPRST_BIT_RSVD]               = 1'b0;
                read_mux[`RPRST_BIT_OCA]                = overcurrent_active;
                read_mux[`RPRST_BIT_PR]                 = port_reset_request
                                                          && port_power_flag;
                read_mux[`RPRST_PLS_HI:`RPRST_PLS_LO]   = link_state_field;
                read_mux[`RPRST_BIT_PP]                 = port_power_flag;
            end
            `RPRST_ADDR_CTRL: begin
                read_mux[`RPRST_CTRL_USB3] = usb3_mode;
                read_mux[`RPRST_CTRL_PP]   = port_power_flag;
            end
            `RPRST_ADDR_STATUS: begin
                read_mux[`RPRST_STAT_BUSY] = timer_busy;
                read_mux[`RPRST_STAT_USB2] = usb2_bus_reset;
                read_mux[`RPRST_STAT_USB3] = usb3_hot_reset;
            end
            default: read_mux = 32'h00000000;
        endcase
    end

    // read data captured in setup so it stands through the access phase
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            prdata <= read_mux;
        end
    end
endmodule // rprst_port

// ---- sim/rprst_port_properties.sv ----
/* Concurrent checks on the ports of rprst_port, bound into every instance.
   Assumes the apb map of rprst_regs.vh and the single clk domain. */
`timescale 1ns/1ns
`include "rprst_regs.vh"
module rprst_port_props #(
    parameter RESET_US = `RPRST_RESET_US
) (
    // clock and reset
    input wire        clk,
    input wire        nrst,
    // apb
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    // link side
    input wire [3:0]  link_state_pin,
    input wire        usb2_bus_reset,
    input wire        usb3_hot_reset,
    input wire [3:0]  link_target,
    input wire        link_target_valid,
    input wire        downstream_forward_enable,
    input wire        port_enabled_flag
);
    localparam int RC = RESET_US * `RPRST_CLK_MHZ;
    wire       in_rst = usb2_bus_reset | usb3_hot_reset;
    wire       wr     = psel & penable & pwrite;
    wire       wr_ps  = wr && paddr == `RPRST_ADDR_PORT_STATUS_CONTROL;
    wire       wr_pr  = wr_ps && pwdata[4];
    reg        u3;
    reg        pw;
    reg [15:0] rc;
    // mode and power live in ctrl, which no port shows, so mirror them here
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            u3 <= 1'h0;
            pw <= 1'h0;
            rc <= 16'h0;
        end else begin
            if (wr && paddr == `RPRST_ADDR_CTRL) begin
                u3 <= pwdata[0];
                pw <= pwdata[1];
            end
            rc <= in_rst ? rc + 16'h1 : 16'h0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_one; !(usb2_bus_reset && usb3_hot_reset); endproperty
    a_one: assert property (p_one) else $error("both reset kinds active");
    property p_start; wr_pr && !in_rst && pw |=> (u3 ? usb3_hot_reset : usb2_bus_reset);
    endproperty
    a_start: assert property (p_start) else $error("reset not started");
    property p_nopw; wr_pr && !pw && !in_rst |=> !in_rst; endproperty
    a_nopw: assert property (p_nopw) else $error("reset without power");
    property p_ignore; wr_pr && in_rst && rc < RC - 4 |=> in_rst; endproperty
    a_ignore: assert property (p_ignore) else $error("reset disturbed");
    property p_len; $fell(in_rst) |-> rc >= RC && rc <= RC + 3; endproperty
    a_len: assert property (p_len) else $error("reset length wrong");
    property p_ped; in_rst |-> !port_enabled_flag; endproperty
    a_ped: assert property (p_ped) else $error("enabled during reset");
    property p_rd; psel && penable && !pwrite && paddr == `RPRST_ADDR_PORT_STATUS_CONTROL
        |-> !prdata[2] && prdata[4] == $past(in_rst); endproperty
    a_rd: assert property (p_rd) else $error("read fields wrong");
    property p_nolws; wr_ps && !pwdata[16] |=> !link_target_valid; endproperty
    a_nolws: assert property (p_nolws) else $error("unstrobed link write");
    property p_code; link_target_valid |-> link_target == 4'h0 || link_target == 4'h3
        || (link_target == 4'h2 && !u3) || (link_target == 4'h5 && u3); endproperty
    a_code: assert property (p_code) else $error("bad link target");
    property p_u3; link_state_pin == 4'h3 [*4] |-> !downstream_forward_enable; endproperty
    a_u3: assert property (p_u3) else $error("traffic in U3");
endmodule // rprst_port_props
bind rprst_port rprst_port_props #(.RESET_US(RESET_US)) i_props (
    .clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .link_state_pin,
    .usb2_bus_reset, .usb3_hot_reset, .link_target, .link_target_valid,
    .downstream_forward_enable, .port_enabled_flag
);

// ---- sim/rprst_phy_model.sv ----
/* Behavioural attached link: reports its state code and obeys link requests.
   Assumes the bench may force a state through set_en and set_code. */
`timescale 1ns/1ns
module rprst_phy_model (
    // clock and reset
    input  wire       clk,
    input  wire       nrst,
    // from the port
    input  wire       link_target_valid,
    input  wire [3:0] link_target,
    input  wire       bus_reset,
    // bench control
    input  wire       set_en,
    input  wire [3:0] set_code,
    input  wire [3:0] dly,
    // link status
    output reg  [3:0] link_state_pin
);
    reg [3:0] pend;
    reg [3:0] cnt;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            link_state_pin <= 4'h5;
            pend           <= 4'h0;
            cnt            <= 4'h0;
        end else if (set_en) begin
            link_state_pin <= set_code;
        end else if (bus_reset) begin
            link_state_pin <= 4'h0;
        end else if (link_target_valid) begin
            pend <= link_target;
            cnt  <= dly;
            if (dly == 4'h0) begin
                link_state_pin <= link_target;
            end
        end else if (cnt != 4'h0) begin
            // a slow link lands the request only after dly cycles
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1) begin
                link_state_pin <= pend;
            end
        end
    end
endmodule // rprst_phy_model

// ---- sim/tb_root_port_reset_link_state_control.sv ----
/* Self-checking bench for rprst_port with the attached link model.
   Assumes the apb map and codes of rprst_regs.vh and a 50 MHz clock. */
`timescale 1ns/1ns
`include "rprst_regs.vh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_root_port_reset_link_state_control;
    typedef struct packed {logic u3, en; logic [3:0] cur, code; logic link_state_write_strobe, v;} rprst_row_t;
    localparam int RC = 50;
    logic        clk, nrst, psel, penable, pwrite, overcurrent_pin, reset_fail_pin;
    logic        port_enabled_in, set_en, seen_v, err, ped_end;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    logic [3:0]  set_code, dly, seen_t;
    wire         pready, pslverr, usb2_bus_reset, usb3_hot_reset, link_target_valid;
    wire         downstream_forward_enable, port_enabled_flag;
    wire [31:0]  prdata;
    wire [3:0]   link_state_pin, link_target;
    int          errors, comparisons, n, hi_cnt;
    rprst_row_t  rows [10] = '{
        '{1'h0, 1'h1, 4'h0, 4'h3, 1'h1, 1'h1}, '{1'h0, 1'h1, 4'h3, 4'h0, 1'h1, 1'h1},
        '{1'h0, 1'h1, 4'h0, 4'h2, 1'h1, 1'h1}, '{1'h1, 1'h1, 4'h0, 4'h2, 1'h1, 1'h0},
        '{1'h1, 1'h0, 4'h4, 4'h5, 1'h1, 1'h1}, '{1'h0, 1'h0, 4'h4, 4'h5, 1'h1, 1'h0},
        '{1'h1, 1'h1, 4'h0, 4'h5, 1'h1, 1'h0}, '{1'h0, 1'h1, 4'h0, 4'h3, 1'h0, 1'h0},
        '{1'h1, 1'h1, 4'h1, 4'h0, 1'h1, 1'h1}, '{1'h0, 1'h0, 4'h0, 4'h3, 1'h1, 1'h0}};

    rprst_port #(.RESET_US(1)) i_dut (.clk, .nrst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .pslverr, .prdata, .overcurrent_pin, .link_state_pin,
        .reset_fail_pin, .usb2_bus_reset, .usb3_hot_reset, .link_target,
        .link_target_valid, .downstream_forward_enable, .port_enabled_in, .port_enabled_flag);
    rprst_phy_model i_phy (.clk, .nrst, .link_target_valid, .link_target,
        .bus_reset(usb2_bus_reset | usb3_hot_reset), .set_en, .set_code, .dly, .link_state_pin);

    always @(posedge clk) begin
        if (link_target_valid === 1'h1) begin
            seen_v <= 1'h1;
            seen_t <= link_target;
        end
        if ((usb2_bus_reset | usb3_hot_reset) === 1'h1) hi_cnt <= hi_cnt + 1;
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'h1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask

    task automatic wait_rst;
        n = 0;
        while ((usb2_bus_reset | usb3_hot_reset) !== 1'h0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        // the neighbour may re-enable the port a cycle later, so take the flag now
        ped_end = port_enabled_flag;
        `CHK("reset length", 1'h1, hi_cnt >= RC && hi_cnt <= RC + 3)
        repeat (4) @(posedge clk);
    endtask

    task automatic print_verdict;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        print_verdict;
    end

    initial begin
        {nrst, psel, penable, pwrite, overcurrent_pin, reset_fail_pin, set_en} = 7'h0;
        {paddr, pwdata, set_code, dly, port_enabled_in, seen_v, seen_t, hi_cnt} = 0;
        repeat (20) @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk);
        foreach (rows[i]) begin
            apb(1'h1, `RPRST_ADDR_CTRL, {30'h0, 1'h1, rows[i].u3});
            port_enabled_in <= rows[i].en;
            set_code        <= rows[i].cur;
            set_en          <= 1'h1;
            dly             <= 4'(i % 3);
            @(posedge clk);
            set_en <= 1'h0;
            repeat (6) @(posedge clk);
            apb(1'h0, `RPRST_ADDR_PORT_STATUS_CONTROL, 32'h0);
            `CHK("link field", rows[i].cur, rd[8:5])
            `CHK("forward", rows[i].en & (rows[i].cur != 4'h3), downstream_forward_enable)
            @(negedge clk) seen_v = 1'h0;
            @(posedge clk);
            apb(1'h1, `RPRST_ADDR_PORT_STATUS_CONTROL, {15'h0, rows[i].link_state_write_strobe, 7'h0, rows[i].code, 5'h0});
            repeat (3) @(negedge clk);
            `CHK("request", rows[i].v, seen_v)
            if (rows[i].v) `CHK("target", rows[i].code, seen_t)
            @(posedge clk);
        end
        $display("link table done");
        nrst <= 1'h0;
        @(negedge clk);
        `CHK("target at reset", 4'h5, link_target)
        repeat (20) @(posedge clk);
        nrst <= 1'h1;
        repeat (4) @(posedge clk);
        apb(1'h0, `RPRST_ADDR_PORT_STATUS_CONTROL, 32'h0);
        `CHK("link field at reset", 4'h5, rd[8:5])
        `CHK("mapped read error", 1'h0, err)
        overcurrent_pin <= 1'h1;
        repeat (4) @(posedge clk);
        apb(1'h1, `RPRST_ADDR_PORT_STATUS_CONTROL, 32'h0000_0004);
        apb(1'h0, `RPRST_ADDR_PORT_STATUS_CONTROL, 32'h0);
        `CHK("overcurrent on", 1'h1, rd[3])
        `CHK("reserved bit", 1'h0, rd[2])
        overcurrent_pin <= 1'h0;
        repeat (4) @(posedge clk);
        apb(1'h0, `RPRST_ADDR_PORT_STATUS_CONTROL, 32'h0);
        `CHK("overcurrent off", 1'h0, rd[3])
        $display("reset and overcurrent done");
        // usb2 port in polling: a bus reset clears enabled and sets it again when it ends
        apb(1'h1, `RPRST_ADDR_CTRL, 32'h0000_0002);
        port_enabled_in <= 1'h1;
        set_code <= `RPRST_LS_POLLING;
        set_en   <= 1'h1;
        @(posedge clk);
        set_en <= 1'h0;
        @(negedge clk) hi_cnt = 0;
        @(posedge clk);
        apb(1'h1, `RPRST_ADDR_PORT_STATUS_CONTROL, 32'h0000_0010);
        `CHK("usb2 reset", 2'h2, {usb2_bus_reset, usb3_hot_reset})
        `CHK("enabled cleared", 1'h0, port_enabled_flag)
        apb(1'h0, `RPRST_ADDR_PORT_STATUS_CONTROL, 32'h0);
        `CHK("reset bit held", 1'h1, rd[4])
        apb(1'h0, `RPRST_ADDR_STATUS, 32'h0);
        `CHK("reset status", 3'h3, rd[2:0])
        apb(1'h1, `RPRST_ADDR_PORT_STATUS_CONTROL, 32'h0000_0010);
        wait_rst;
        `CHK("enabled again", 1'h1, ped_end)
        apb(1'h0, `RPRST_ADDR_PORT_STATUS_CONTROL, 32'h0);
        `CHK("reset bit done", 1'h0, rd[4])
        apb(1'h1, `RPRST_ADDR_CTRL, 32'h0000_0003);
        reset_fail_pin <= 1'h1;
        @(negedge clk) hi_cnt = 0;
        @(posedge clk);
        apb(1'h1, `RPRST_ADDR_PORT_STATUS_CONTROL, 32'h0000_0010);
        `CHK("hot reset", 2'h1, {usb2_bus_reset, usb3_hot_reset})
        wait_rst;
        `CHK("failed reset", 1'h0, ped_end)
        reset_fail_pin <= 1'h0;
        apb(1'h1, `RPRST_ADDR_CTRL, 32'h0);
        apb(1'h1, `RPRST_ADDR_PORT_STATUS_CONTROL, 32'h0000_0010);
        `CHK("no reset unpowered", 2'h0, {usb2_bus_reset, usb3_hot_reset})
        apb(1'h0, `RPRST_ADDR_PORT_STATUS_CONTROL, 32'h0);
        `CHK("reset bit unpowered", 1'h0, rd[4])
        apb(1'h0, 12'h0FC, 32'h0);
        `CHK("unmapped read", 32'h0, rd)
        `CHK("unmapped error", 1'h1, err)
        $display("port reset done");
        print_verdict;
    end
endmodule // tb_root_port_reset_link_state_control
